// [src/dmc_map.svh]
/*
  Register offsets, field positions, event bits and sizes of the cache policy controller.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_CTRL_OFS  8'h00
`define DMC_HIST_OFS  8'h04
`define DMC_STAT_OFS  8'h08
`define DMC_MASK_OFS  8'h0c
`define DMC_CTRL_EN   0
`define DMC_CTRL_FPAR 1
`define DMC_CTRL_INV  2
`define DMC_EV_PAR    0
`define DMC_EV_DMA    1
`define DMC_EV_INV    2
`define DMC_NEV       3
`define DMC_HIST_LEN  6
`define DMC_NENT      4096
`define DMC_IDX_W     12
`define DMC_TAG_W     9
`define DMC_ADDR_W    22
`define DMC_DATA_W    16
`define DMC_IO_LABEL  9'h1ff
`define DMC_LAST_IDX  12'hfff
`endif

// [src/dmc_pkg.sv]
/*
  Types of the cache policy controller: cache entry, controller state and the state record.
  Assumes dmc_map.svh is on the include path.
*/
`include "dmc_map.svh"
package dmc_pkg;
  typedef logic [`DMC_ADDR_W-1:0] dmc_addr_t;
  typedef logic [`DMC_DATA_W-1:0] dmc_data_t;
  typedef logic [`DMC_IDX_W-1:0]  dmc_idx_t;
  typedef logic [`DMC_TAG_W-1:0]  dmc_tag_t;
  typedef struct packed {
    logic      valid;
    dmc_tag_t  tag;
    logic      ptag;
    dmc_data_t data;
    logic      p0;
    logic      p1;
  } dmc_entry_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_MEM, ST_FLUSH} dmc_st_t;
  typedef struct packed {
    dmc_st_t                  st;
    logic                     en;
    logic                     fpar;
    logic                     flush_req;
    dmc_idx_t                 fcnt;
    dmc_addr_t                addr;
    logic                     we;
    logic                     bm;
    dmc_data_t                wd;
    logic                     cach;
    logic [`DMC_HIST_LEN-1:0] hist;
    logic [`DMC_NEV-1:0]      stat;
    logic [`DMC_NEV-1:0]      mask;
    logic                     cpu_ack;
    dmc_data_t                cpu_rdata;
    logic                     mem_req;
    logic                     mem_we;
    logic [1:0]               mem_be;
    logic                     wb_ack;
    logic [31:0]              wb_dat;
    logic                     irq;
  } dmc_state_t;
endpackage : dmc_pkg

// [src/dmc_ram_if.sv]
/*
  Port between the controller and its entry store: one read port, one write port.
  Assumes the store registers read data one clock after the index.
*/
`timescale 1ns/1ps
`default_nettype none
interface dmc_ram_if;
  import dmc_pkg::*;
  dmc_idx_t   rd_idx;
  dmc_entry_t rd_ent;
  logic       we;
  dmc_idx_t   wr_idx;
  dmc_entry_t wr_ent;
  modport ctl (output rd_idx, we, wr_idx, wr_ent, input rd_ent);
  modport ram (input rd_idx, we, wr_idx, wr_ent, output rd_ent);
endinterface : dmc_ram_if
`default_nettype wire

// [src/dmc_cache_ram.sv]
/*
  Entry store of the direct mapped cache, one entry per index.
  Assumes a single clock; a write to the index being read is forwarded to the read data.
*/
`include "dmc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dmc_cache_ram (
  input wire logic clk_i,
  dmc_ram_if.ram   port
);
  import dmc_pkg::*;
  dmc_entry_t mem [0:`DMC_NENT-1];

  always_ff @(posedge clk_i) begin
    if (port.we) begin
      mem[port.wr_idx] <= port.wr_ent;
    end
    if (port.we && port.wr_idx == port.rd_idx) begin
      port.rd_ent <= port.wr_ent;
    end else begin
      port.rd_ent <= mem[port.rd_idx];
    end
  end
endmodule : dmc_cache_ram
`default_nettype wire

// [src/dmc_cache_ctl.sv]
/*
  Cache policy controller: direct mapped write-through cache between core and backing store,
  with DMA snooping, control, history, status and mask registers on a classic Wishbone slave.
  Assumes one clock, a core that holds its request until acknowledged, and a backing store
  that answers each request with a one-cycle acknowledge.
*/
// Implementation choices: the Wishbone slave port and the address map.
// Behaviour
// [RULE1] References whose label is the I/O page never hit and are never allocated.
// [RULE2] References flagged for bypass by memory management are neither stored nor served from the cache.
// [RULE3] A control register bit turns the cache on or off.
// [RULE4] A control register bit makes stored entries carry wrong parity for diagnostics.
// [RULE5] A control register bit invalidates every entry.
// [RULE6] A readable history register holds hit or miss for the last six references.
// [RULE7] The cache is direct mapped, 4096 word entries, 12-bit index, 9-bit tag compared with the label.
// [RULE8] A hit needs a tag match, a set valid bit and no parity error.
// [RULE9] Every core write goes to backing store together with any cache update.
// [RULE10] Every DMA access, block mode included, invalidates the entry at its address.
// [RULE11] While disabled every reference goes to backing store and nothing is allocated or updated.
`include "dmc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dmc_cache_ctl (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cpu_req_i,
  input  wire logic              cpu_we_i,
  input  wire logic              cpu_byte_i,
  input  wire logic              cpu_bypass_i,
  input  wire dmc_pkg::dmc_addr_t cpu_addr_i,
  input  wire dmc_pkg::dmc_data_t cpu_wdata_i,
  output var  logic              cpu_ack_o,
  output var  dmc_pkg::dmc_data_t cpu_rdata_o,
  output var  logic              mem_req_o,
  output var  logic              mem_we_o,
  output var  logic [1:0]        mem_be_o,
  output var  dmc_pkg::dmc_addr_t mem_addr_o,
  output var  dmc_pkg::dmc_data_t mem_wdata_o,
  input  wire logic              mem_ack_i,
  input  wire dmc_pkg::dmc_data_t mem_rdata_i,
  input  wire logic              dma_valid_i,
  input  wire dmc_pkg::dmc_addr_t dma_addr_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  output var  logic              irq_o
);
  import dmc_pkg::*;

  dmc_state_t r;
  dmc_state_t next_r;
  dmc_ram_if  ram ();

  dmc_cache_ram u_ram (
    .clk_i (clk_i),
    .port  (ram)
  );

  // Index and label fields of a 22-bit address
  function automatic dmc_idx_t idx_of(input dmc_addr_t a);
    return a[`DMC_IDX_W:1];
  endfunction : idx_of

  function automatic dmc_tag_t label_of(input dmc_addr_t a);
    return a[`DMC_ADDR_W-1:`DMC_IDX_W+1];
  endfunction : label_of

  // Entry with parity: tag even, low byte even, high byte odd
  function automatic dmc_entry_t mk_entry(input dmc_tag_t t, input dmc_data_t d, input logic fp);
    dmc_entry_t e;
    e.valid = 1'b1;
    e.tag   = t;
    e.ptag  = ^t;
    e.data  = d;
    e.p0    = (^d[7:0]) ^ fp; // [RULE4]
    e.p1    = ~^d[15:8];
    return e;
  endfunction : mk_entry

  dmc_entry_t ent;
  logic       par_bad;
  logic       hit;
  dmc_data_t  mdata;
  logic       wb_go;

  assign ent     = ram.rd_ent;
  assign par_bad = ent.valid && (ent.ptag != ^ent.tag || ent.p0 != ^ent.data[7:0] || ent.p1 != ~^ent.data[15:8]);
  assign hit     = r.cach && ent.valid && ent.tag == label_of(r.addr) && !par_bad; // [RULE7] [RULE8]
  assign mdata   = !r.bm ? r.wd : (r.addr[0] ? {r.wd[15:8], ent.data[7:0]} : {ent.data[15:8], r.wd[7:0]});
  assign wb_go   = wb_cyc_i && wb_stb_i && !r.wb_ack;

  always_comb begin
    logic [`DMC_NEV-1:0] ev;
    logic                clr;
    ev          = '0;
    clr         = 1'b0;
    next_r      = r;
    next_r.cpu_ack = 1'b0;
    next_r.wb_ack  = 1'b0;
    ram.rd_idx  = (r.st == ST_IDLE) ? idx_of(cpu_addr_i) : idx_of(r.addr);
    ram.we      = dma_valid_i; // [RULE10]
    ram.wr_idx  = idx_of(dma_addr_i);
    ram.wr_ent  = '0;
    if (dma_valid_i) begin
      ev[`DMC_EV_DMA] = 1'b1;
    end
    unique case (r.st)
      ST_IDLE: begin
        if (r.flush_req) begin
          next_r.st   = ST_FLUSH;
          next_r.fcnt = '0;
        end else if (cpu_req_i && !r.cpu_ack) begin
          next_r.addr = cpu_addr_i;
          next_r.we   = cpu_we_i;
          next_r.bm   = cpu_byte_i;
          next_r.wd   = cpu_wdata_i;
          next_r.cach = r.en && !cpu_bypass_i && label_of(cpu_addr_i) != `DMC_IO_LABEL; // [RULE1] [RULE2] [RULE11]
          next_r.st   = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (!dma_valid_i) begin
          next_r.hist = {r.hist[`DMC_HIST_LEN-2:0], hit}; // [RULE6]
          if (par_bad) begin
            ev[`DMC_EV_PAR] = 1'b1;
          end
          if (hit && !r.we) begin
            next_r.cpu_ack   = 1'b1;
            next_r.cpu_rdata = ent.data;
            next_r.st        = ST_IDLE;
          end else begin
            next_r.mem_req = 1'b1; // [RULE9]
            next_r.mem_we  = r.we;
            next_r.mem_be  = r.bm ? (r.addr[0] ? 2'b10 : 2'b01) : 2'b11;
            next_r.st      = ST_MEM;
            if (r.we && r.cach && (hit || !r.bm)) begin
              ram.we     = 1'b1; // [RULE9]
              ram.wr_idx = idx_of(r.addr);
              ram.wr_ent = mk_entry(label_of(r.addr), mdata, r.fpar);
            end
          end
        end
      end
      ST_MEM: begin
        if (mem_ack_i) begin
          next_r.mem_req   = 1'b0;
          next_r.mem_we    = 1'b0;
          next_r.cpu_ack   = 1'b1;
          next_r.cpu_rdata = mem_rdata_i;
          next_r.st        = ST_IDLE;
          if (!r.we && r.cach && !dma_valid_i) begin
            ram.we     = 1'b1; // [RULE11]
            ram.wr_idx = idx_of(r.addr);
            ram.wr_ent = mk_entry(label_of(r.addr), mem_rdata_i, r.fpar);
          end
        end
      end
      ST_FLUSH: begin
        if (!dma_valid_i) begin
          ram.we      = 1'b1; // [RULE5]
          ram.wr_idx  = r.fcnt;
          next_r.fcnt = r.fcnt + 1'b1;
          if (r.fcnt == `DMC_LAST_IDX) begin
            next_r.st        = ST_IDLE;
            next_r.flush_req = 1'b0;
            ev[`DMC_EV_INV]  = 1'b1;
          end
        end
      end
    endcase
    if (wb_go) begin
      next_r.wb_ack = 1'b1;
      next_r.wb_dat = '0;
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `DMC_CTRL_OFS) begin
          next_r.en   = wb_dat_i[`DMC_CTRL_EN]; // [RULE3]
          next_r.fpar = wb_dat_i[`DMC_CTRL_FPAR]; // [RULE4]
          if (wb_dat_i[`DMC_CTRL_INV]) begin
            next_r.flush_req = 1'b1; // [RULE5]
          end
        end else if (wb_adr_i == `DMC_MASK_OFS) begin
          next_r.mask = wb_dat_i[`DMC_NEV-1:0];
        end
      end else if (!wb_we_i) begin
        if (wb_adr_i == `DMC_CTRL_OFS) begin
          next_r.wb_dat = {29'h0, r.flush_req, r.fpar, r.en};
        end else if (wb_adr_i == `DMC_HIST_OFS) begin
          next_r.wb_dat = {26'h0, r.hist}; // [RULE6]
        end else if (wb_adr_i == `DMC_STAT_OFS) begin
          next_r.wb_dat = {29'h0, r.stat};
          clr           = 1'b1;
        end else if (wb_adr_i == `DMC_MASK_OFS) begin
          next_r.wb_dat = {29'h0, r.mask};
        end
      end
    end
    next_r.stat = (clr ? '0 : r.stat) | ev;
    next_r.irq  = |(next_r.stat & next_r.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r           <= '0;
      r.flush_req <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign cpu_ack_o   = r.cpu_ack;
  assign cpu_rdata_o = r.cpu_rdata;
  assign mem_req_o   = r.mem_req;
  assign mem_we_o    = r.mem_we;
  assign mem_be_o    = r.mem_be;
  assign mem_addr_o  = r.addr;
  assign mem_wdata_o = r.wd;
  assign wb_dat_o    = r.wb_dat;
  assign wb_ack_o    = r.wb_ack;
  assign irq_o       = r.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_io_page_bypass: assert property ((r.st == ST_LOOK && label_of(r.addr) == `DMC_IO_LABEL && !dma_valid_i)
    |=> mem_req_o && !cpu_ack_o) else $error("I/O page reference did not go to backing store"); // [RULE1]
  a_mmu_no_store: assert property ((r.st == ST_MEM && !r.cach && !dma_valid_i) |-> !ram.we)
    else $error("Uncached reference wrote the cache"); // [RULE2]
  a_ctrl_disable: assert property ((!r.en && r.st == ST_LOOK && !dma_valid_i) |=> mem_req_o)
    else $error("Disabled cache served a reference"); // [RULE3]
  a_force_parity: assert property ((ram.we && ram.wr_ent.valid && r.fpar) |-> ram.wr_ent.p0 != ^ram.wr_ent.data[7:0])
    else $error("Forced parity not applied"); // [RULE4]
  a_flush_clears: assert property ((r.st == ST_FLUSH && ram.we) |-> !ram.wr_ent.valid)
    else $error("Flush wrote a valid entry"); // [RULE5]
  a_hist_hit: assert property ((r.st == ST_LOOK && !r.we && hit && !dma_valid_i) |=> cpu_ack_o && r.hist[0])
    else $error("Read hit not answered or not recorded"); // [RULE6]
  a_hit_match: assert property ((r.st == ST_LOOK && hit) |-> ent.valid && ent.tag == label_of(r.addr) && !par_bad)
    else $error("Hit without tag match, valid bit or good parity"); // [RULE8]
  a_write_through: assert property ((r.st == ST_LOOK && r.we && !dma_valid_i) |=> mem_req_o && mem_we_o [*1] ##0 r.st == ST_MEM)
    else $error("Write not forwarded to backing store"); // [RULE9]
  a_dma_inval: assert property (dma_valid_i |-> ram.we && !ram.wr_ent.valid && ram.wr_idx == idx_of(dma_addr_i))
    else $error("DMA access did not invalidate its entry"); // [RULE10]
  a_off_no_alloc: assert property (!r.en && !$past(r.en, 2) |-> !(ram.we && ram.wr_ent.valid))
    else $error("Disabled cache allocated an entry"); // [RULE11]

  c_read_hit: cover property (r.st == ST_LOOK && hit && !r.we);
  c_read_fill: cover property (r.st == ST_MEM && mem_ack_i && r.cach && !r.we);
  c_flush_done: cover property (r.st == ST_FLUSH ##1 r.st == ST_IDLE);
  c_irq: cover property (irq_o);
endmodule : dmc_cache_ctl
`default_nettype wire

// [verification/dmc_mem_model.sv]
/*
  Backing store model: answers each request after lat_i extra cycles with a one-cycle ack.
  Assumes the controller holds its request, address and data until the ack.
*/
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_model (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               req_i,
  input  wire logic               we_i,
  input  wire logic [1:0]         be_i,
  input  wire dmc_pkg::dmc_addr_t addr_i,
  input  wire dmc_pkg::dmc_data_t wdata_i,
  input  wire logic [3:0]         lat_i,
  output var  logic               ack_o,
  output var  dmc_pkg::dmc_data_t rdata_o,
  output var  int                 acc_o
);
  import dmc_pkg::*;
  dmc_data_t  mem [int];
  dmc_data_t  d;
  logic [3:0] wait_q;
  always_ff @(posedge clk_i) begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    d = mem.exists(int'(addr_i[21:1])) ? mem[int'(addr_i[21:1])] : addr_i[16:1] ^ 16'h3c3c;
    if (rst_i) begin
      wait_q  <= 4'h0;
      acc_o   <= 0;
      rdata_o <= 16'h0;
    end else if (req_i && !ack_o) begin
      if (wait_q < lat_i) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        wait_q <= 4'h0;
        ack_o  <= 1'b1;
        acc_o  <= acc_o + 1;
        if (we_i) begin
          if (be_i[0]) d[7:0] = wdata_i[7:0];
          if (be_i[1]) d[15:8] = wdata_i[15:8];
          mem[int'(addr_i[21:1])] = d;
        end else begin
          rdata_o <= d;
        end
      end
    end
  end
endmodule : dmc_mem_model
`default_nettype wire

// [verification/direct_map_cache_policy_ctl_tb.sv]
/*
  Testbench of the cache policy controller: register and core access tasks with expected values.
  Assumes the backing store model and the design sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module direct_map_cache_policy_ctl_tb;
  import dmc_pkg::*;
  logic clk_i, rst_i, creq, cwe, cbyte, cbyp, cack, mreq, mwe, mack, dmav, cyc, stb, wwe, wack, irq;
  logic [1:0]  mbe;
  logic [3:0]  lat, sel;
  logic [7:0]  adr;
  logic [31:0] wdat, wrd, rv;
  dmc_addr_t   caddr, maddr, dmaa;
  dmc_data_t   cwd, crd, mwd, mrd, cd;
  int          acc, acc0, bad_count, checked;
  dmc_data_t   shadow [int];
  localparam dmc_addr_t D1 = 22'h002468, D2 = 22'h00246a, D3 = 22'h202468;
  localparam dmc_addr_t D4 = 22'h001000, IO = 22'h3fe010;

  dmc_cache_ctl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(creq), .cpu_we_i(cwe),
    .cpu_byte_i(cbyte), .cpu_bypass_i(cbyp), .cpu_addr_i(caddr), .cpu_wdata_i(cwd),
    .cpu_ack_o(cack), .cpu_rdata_o(crd), .mem_req_o(mreq), .mem_we_o(mwe), .mem_be_o(mbe),
    .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_ack_i(mack), .mem_rdata_i(mrd),
    .dma_valid_i(dmav), .dma_addr_i(dmaa), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wrd), .wb_ack_o(wack), .irq_o(irq));
  dmc_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq), .we_i(mwe), .be_i(mbe),
    .addr_i(maddr), .wdata_i(mwd), .lat_i(lat), .ack_o(mack), .rdata_o(mrd), .acc_o(acc));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_ack(ref logic ack);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 6000);
    if (n >= 6000) begin
      bad_count++;
      $display("Error at %0t: no answer", $time);
      report_and_stop();
    end
  endtask : wait_ack

  task automatic wb(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    wwe  <= we;
    adr  <= a;
    wdat <= d;
    wait_ack(wack);
    q = wrd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // n_mem: backing store accesses this reference must cause
  // cbyte selects a byte write; address bit0 picks the lane
  task automatic cpu(logic we, logic byp, dmc_addr_t a, dmc_data_t d, int n_mem);
    int k;
    k     = int'(a[21:1]);
    acc0  = acc;
    creq  <= 1'b1;
    cwe   <= we;
    cbyp  <= byp;
    caddr <= a;
    cwd   <= d;
    wait_ack(cack);
    cd = crd;
    creq <= 1'b0;
    @(posedge clk_i);
    if (we) begin
      cd = shadow.exists(k) ? shadow[k] : a[16:1] ^ 16'h3c3c;
      if (!cbyte || !a[0]) cd[7:0] = d[7:0];
      if (!cbyte || a[0]) cd[15:8] = d[15:8];
      shadow[k] = cd;
    end else begin
      chk(cd, shadow.exists(k) ? shadow[k] : a[16:1] ^ 16'h3c3c);
    end
    chk(acc - acc0, n_mem);
  endtask : cpu

  task automatic wait_inv();
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h00, 32'h0, rv);
      n++;
    end while (rv[2] === 1'b1 && n < 3000);
    chk(rv[2], 1'b0);
    if (rv[2] !== 1'b0) report_and_stop();
  endtask : wait_inv

  initial begin
    {creq, cwe, cbyte, cbyp, dmav, cyc, stb, wwe} = '0;
    {caddr, cwd, dmaa, adr, wdat} = '0;
    sel   = 4'hf;
    lat   = 4'h0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0, rv);
    chk(rv, 32'h4);
    wait_inv();
    wb(1'b0, 8'h08, 32'h0, rv);
    chk(rv, 32'h4);
    wb(1'b1, 8'h10, 32'hffffffff, rv);
    wb(1'b0, 8'h10, 32'h0, rv);
    chk(rv, 32'h0);
    cpu(1'b0, 1'b0, D1, 16'h0, 1);
    cpu(1'b0, 1'b0, D1, 16'h0, 1);
    wb(1'b0, 8'h04, 32'h0, rv);
    chk(rv, 32'h0);
    wb(1'b1, 8'h00, 32'h1, rv);
    lat <= 4'h3;
    for (int i = 0; i < 7; i++) cpu(1'b0, 1'b0, (i == 2 || i == 5) ? D2 : D1, 16'h0, i == 0 || i == 2);
    wb(1'b0, 8'h04, 32'h0, rv);
    chk(rv, 32'h2f);
    cpu(1'b0, 1'b0, D3, 16'h0, 1);
    cpu(1'b0, 1'b0, D1, 16'h0, 1);
    cpu(1'b1, 1'b0, D1, 16'hbeef, 1);
    cpu(1'b0, 1'b0, D1, 16'h0, 0);
    cbyte <= 1'b1;
    cpu(1'b1, 1'b0, 22'h002469, 16'h12ab, 1);
    cpu(1'b1, 1'b0, 22'h000101, 16'h5a00, 1);
    cbyte <= 1'b0;
    cpu(1'b0, 1'b0, D1, 16'h0, 0);
    cpu(1'b0, 1'b0, 22'h000101, 16'h0, 1);
    cpu(1'b0, 1'b1, D2, 16'h0, 1);
    cpu(1'b0, 1'b1, D4, 16'h0, 1);
    cpu(1'b0, 1'b0, D4, 16'h0, 1);
    cpu(1'b1, 1'b0, IO, 16'h1234, 1);
    cpu(1'b0, 1'b0, IO, 16'h0, 1);
    cpu(1'b0, 1'b0, IO, 16'h0, 1);
    wb(1'b0, 8'h08, 32'h0, rv);
    chk(rv, 32'h0);
    dmav <= 1'b1;
    dmaa <= D1;
    @(posedge clk_i);
    dmaa <= D2;
    @(posedge clk_i);
    dmav <= 1'b0;
    @(posedge clk_i);
    cpu(1'b0, 1'b0, D1, 16'h0, 1);
    cpu(1'b0, 1'b0, D2, 16'h0, 1);
    wb(1'b0, 8'h08, 32'h0, rv);
    chk(rv, 32'h2);
    wb(1'b1, 8'h00, 32'h5, rv);
    wait_inv();
    wb(1'b0, 8'h08, 32'h0, rv);
    chk(rv, 32'h4);
    cpu(1'b0, 1'b0, D1, 16'h0, 1);
    wb(1'b1, 8'h00, 32'h3, rv);
    cpu(1'b0, 1'b0, D4, 16'h0, 1);
    cpu(1'b0, 1'b0, D4, 16'h0, 1);
    chk(irq, 1'b0);
    wb(1'b1, 8'h0c, 32'h1, rv);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wb(1'b0, 8'h08, 32'h0, rv);
    chk(rv, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    report_and_stop();
  end
endmodule : direct_map_cache_policy_ctl_tb
`default_nettype wire
